// file: logic/sss_top.sv
// Purpose: Power-good, main rail sequencing, board alert/fault and LED status.
// Assumes: Board inputs are asynchronous; rail status inputs are analogue comparator levels.
// Notes:   All delays run from one free-running millisecond tick.
// Functional notes
// [RULE_01] Power-good only with both rails regulated.
// [RULE_02] Alert low forces fan to maximum.
// [RULE_03] Alert ignored in standby with main off.
// [RULE_04] Board fault high shuts outputs down.
// [RULE_05] Power-good 5 to 400 ms after regulation.
// [RULE_06] Main starts 50-1000 ms after standby.
// [RULE_07] Power-good drops 1 ms before main.
// [RULE_08] Power-good held 4 ms after input loss.
// [RULE_09] Power-good stays low at least 100 ms.
// [RULE_10] Main regulated 5-400 ms after enable.
// [RULE_11] Main disabled within 1 ms of disable.
// [RULE_12] Power-good low within 4 ms of disable.
// [RULE_13] Dropped rail kept off for 1 s.
// [RULE_14] LED off without any output or standby.
// [RULE_15] LED pattern by fixed priority order.
// [RULE_16] Shutdowns and big fan error: solid amber.
// [RULE_17] Warnings and minor fan error: blinking amber. No minor fan error input here; only WARN_ACTIVE blinks amber.
// [RULE_18] Both rails regulated gives solid green.
// [RULE_19] Enable low turns main on, clears latches.
// [RULE_20] One millisecond tick, synchronised board inputs.
`timescale 1ns/100ps
module sss_top
  import sss_pkg::*;
#(parameter int unsigned TICK_CYC = TICK_CYCLES)
(
  input  wire logic CLOCK,
  input  wire logic RESET,
  input  wire logic MAIN_ENABLE_N,
  input  wire logic BOARD_ALERT_N,
  input  wire logic BOARD_FAULT_IN,
  input  wire logic DC_INPUT_OK,
  input  wire logic STANDBY_IN_REG,
  input  wire logic MAIN_IN_REG,
  input  wire logic PARALLEL_STANDBY,
  input  wire logic FAULT_SHUTDOWN,
  input  wire logic FAN_ERROR_MAJOR,
  input  wire logic WARN_ACTIVE,
  input  wire logic BOOTLOADING,
  input  wire logic FAN_AUTO_MAX,
  output logic      POWER_GOOD,
  output logic      STANDBY_ENABLE,
  output logic      MAIN_OUTPUT_RAIL_EN,
  output logic      FAN_FORCE_MAX,
  output logic      LED_GREEN,
  output logic      LED_AMBER
);
  import sss_pkg::*;

  function automatic logic [MS_W-1:0] ms_const(input int unsigned ms);
    ms_const = MS_W'(ms);
  endfunction : ms_const

  // ----------------------------------------------------------------
  // Input synchronisers and millisecond tick
  // ----------------------------------------------------------------
  logic [1:0]        en_n_sync_q;
  logic [1:0]        alert_sync_q;
  logic [1:0]        fault_sync_q;
  logic              en_n_prev_q;
  logic [TICK_W-1:0] tick_cnt_q;
  logic              tick;
  localparam logic [TICK_W-1:0] TICK_END = TICK_W'(TICK_CYC - 1);

  // [RULE_20] Synchronise board inputs.
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      en_n_sync_q  <= 2'h3;
      alert_sync_q <= 2'h3;
      fault_sync_q <= 2'h0;
      en_n_prev_q  <= 1'b1;
    end else begin
      en_n_sync_q  <= {en_n_sync_q[0], MAIN_ENABLE_N};
      alert_sync_q <= {alert_sync_q[0], BOARD_ALERT_N};
      fault_sync_q <= {fault_sync_q[0], BOARD_FAULT_IN};
      en_n_prev_q  <= en_n_sync_q[1];
    end
  end

  // [RULE_20] Free-running millisecond tick.
  always_ff @(posedge CLOCK) begin
    if (RESET || tick_cnt_q == TICK_END) begin
      tick_cnt_q <= TICK_ZERO;
    end else begin
      tick_cnt_q <= tick_cnt_q + TICK_ONE;
    end
  end
  assign tick = (tick_cnt_q == TICK_END);

  logic en_n;
  logic fault;
  logic en_fall;
  assign en_n    = en_n_sync_q[1];
  assign fault   = fault_sync_q[1];
  assign en_fall = en_n_prev_q && !en_n;

  // ----------------------------------------------------------------
  // Standby rail retry and main rail sequencer
  // ----------------------------------------------------------------
  logic [MS_W-1:0] sb_off_q;
  logic            sb_dropped_q;
  logic            sb_ok;

  // [RULE_13] Standby kept off after drop.
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      sb_off_q     <= MS_ZERO;
      sb_dropped_q <= 1'b0;
    end else if (STANDBY_ENABLE && sb_dropped_q && !STANDBY_IN_REG) begin
      sb_off_q     <= ms_const(RAIL_OFF_MS);
      sb_dropped_q <= 1'b0;
    end else if (sb_off_q != MS_ZERO) begin
      if (tick) begin
        sb_off_q <= sb_off_q - MS_ONE;
      end
    end else begin
      sb_dropped_q <= STANDBY_IN_REG;
    end
  end
  assign STANDBY_ENABLE = (sb_off_q == MS_ZERO);
  assign sb_ok          = STANDBY_IN_REG && STANDBY_ENABLE;

  sss_state_t      state_q;
  logic [MS_W-1:0] seq_cnt_q;
  logic            fault_latch_q;
  logic            stop_req;

  // [RULE_19] Latched faults clear on enable toggle.
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      fault_latch_q <= 1'b0;
    end else if (FAULT_SHUTDOWN) begin
      fault_latch_q <= 1'b1;
    end else if (en_fall) begin
      fault_latch_q <= 1'b0;
    end
  end

  // [RULE_04] Board fault demands shutdown.
  assign stop_req = en_n || fault || fault_latch_q || !sb_ok || !DC_INPUT_OK;

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      state_q   <= SSS_OFF;
      seq_cnt_q <= MS_ZERO;
    end else begin
      if (tick && seq_cnt_q != MS_ZERO) begin
        seq_cnt_q <= seq_cnt_q - MS_ONE;
      end
      unique case (state_q)
        SSS_OFF: begin
          // [RULE_06] Standby to main delay.
          if (!stop_req) begin
            state_q   <= SSS_WAIT;
            seq_cnt_q <= en_fall ? ms_const(EN_TO_MAIN_MS) : ms_const(SB_TO_MAIN_MS);
          end
        end
        SSS_WAIT: begin
          if (stop_req) begin
            state_q <= SSS_OFF;
          end else if (seq_cnt_q == MS_ZERO) begin
            state_q <= SSS_RISE;
          end
        end
        SSS_RISE, SSS_ON: begin
          // [RULE_11] Disable main within 1 ms.
          if (en_n || fault || fault_latch_q || !sb_ok || (!DC_INPUT_OK && !POWER_GOOD)) begin
            state_q <= SSS_OFF;
          end else if (state_q == SSS_ON && !MAIN_IN_REG) begin
            // [RULE_13] Main kept off after drop.
            state_q   <= SSS_HOLD;
            seq_cnt_q <= ms_const(RAIL_OFF_MS);
          end else if (MAIN_IN_REG) begin
            state_q <= SSS_ON;
          end
        end
        SSS_HOLD: begin
          if (seq_cnt_q == MS_ZERO) begin
            state_q <= SSS_OFF;
          end
        end
        default: begin
          state_q <= SSS_OFF;
        end
      endcase
    end
  end

  // [RULE_10] Main enabled after the sequencing wait.
  assign MAIN_OUTPUT_RAIL_EN = (state_q == SSS_RISE) || (state_q == SSS_ON);

  // ----------------------------------------------------------------
  // Power-good
  // ----------------------------------------------------------------
  logic [MS_W-1:0] pg_cnt_q;
  logic [MS_W-1:0] pg_low_q;
  logic [MS_W-1:0] hold_q;
  logic            both_ok;
  assign both_ok = MAIN_IN_REG && sb_ok && (state_q == SSS_ON) && !en_n && !fault;

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      POWER_GOOD <= 1'b0;
      pg_cnt_q   <= ms_const(PG_DEL_MS);
      pg_low_q   <= ms_const(PG_LOW_MS);
      hold_q     <= ms_const(PG_HOLDUP_MS + 1);
    end else if (POWER_GOOD) begin
      // [RULE_08] Hold-up on input loss.
      if (!DC_INPUT_OK && hold_q != MS_ZERO && both_ok) begin
        if (tick) begin
          hold_q <= hold_q - MS_ONE;
        end
      // [RULE_07] Warn ahead of main dropping.
      end else if (!DC_INPUT_OK || !both_ok) begin
        // [RULE_12] Drop on disable.
        POWER_GOOD <= 1'b0;
        pg_low_q   <= ms_const(PG_LOW_MS + 1);
      end
    end else begin
      // One extra tick keeps a partly elapsed first tick from shortening a minimum time.
      hold_q <= ms_const(PG_HOLDUP_MS + 1);
      if (tick && pg_low_q != MS_ZERO) begin
        pg_low_q <= pg_low_q - MS_ONE;
      end
      if (!both_ok || !DC_INPUT_OK) begin
        pg_cnt_q <= ms_const(PG_DEL_MS);
      end else if (tick && pg_cnt_q != MS_ZERO) begin
        pg_cnt_q <= pg_cnt_q - MS_ONE;
      // [RULE_05] Assert after delay. [RULE_09] Minimum low time.
      end else if (pg_cnt_q == MS_ZERO && pg_low_q == MS_ZERO) begin
        // [RULE_01] Both rails in regulation.
        POWER_GOOD <= 1'b1;
        pg_cnt_q   <= ms_const(PG_DEL_MS);
      end
    end
  end

  // ----------------------------------------------------------------
  // Fan override
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      FAN_FORCE_MAX <= 1'b0;
    end else if (!MAIN_OUTPUT_RAIL_EN) begin
      // [RULE_03] Standby ignores alert.
      FAN_FORCE_MAX <= FAN_AUTO_MAX;
    end else begin
      // [RULE_02] Alert forces maximum.
      FAN_FORCE_MAX <= !alert_sync_q[1] || FAN_AUTO_MAX;
    end
  end

  // ----------------------------------------------------------------
  // LED
  // ----------------------------------------------------------------
  logic [MS_W-1:0] blink_cnt_q;
  logic            blink1_q;
  logic            blink2_q;
  sss_led_t        led_d;

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      blink_cnt_q <= MS_ZERO;
      blink1_q    <= 1'b0;
      blink2_q    <= 1'b0;
    end else if (tick) begin
      blink_cnt_q <= (blink_cnt_q == ms_const(BLINK_1HZ_MS - 1)) ? MS_ZERO : blink_cnt_q + MS_ONE;
      if (blink_cnt_q == ms_const(BLINK_1HZ_MS - 1)) begin
        blink1_q <= !blink1_q;
      end
      if (blink_cnt_q == ms_const(BLINK_2HZ_MS - 1) || blink_cnt_q == ms_const(BLINK_1HZ_MS - 1)) begin
        blink2_q <= !blink2_q;
      end
    end
  end

  // [RULE_15] First match in fixed order wins.
  always_comb begin
    led_d = SSS_LED_OFF;
    // [RULE_14] Nothing present, LED off.
    if ((!MAIN_OUTPUT_RAIL_EN || !DC_INPUT_OK) && !sb_ok && !PARALLEL_STANDBY) begin
      led_d = SSS_LED_OFF;
    end else if (en_n) begin
      led_d = blink1_q ? SSS_LED_GREEN : SSS_LED_OFF;
    // [RULE_16] Shutdown conditions solid amber.
    end else if (FAULT_SHUTDOWN || fault_latch_q || FAN_ERROR_MAJOR || fault || !DC_INPUT_OK ||
                 state_q == SSS_HOLD || !sb_ok) begin
      led_d = SSS_LED_AMBER;
    // [RULE_17] Warnings blink amber.
    end else if (WARN_ACTIVE) begin
      led_d = blink1_q ? SSS_LED_AMBER : SSS_LED_OFF;
    end else if (BOOTLOADING) begin
      led_d = blink2_q ? SSS_LED_GREEN : SSS_LED_OFF;
    // [RULE_18] Both rails good gives green.
    end else if (MAIN_IN_REG && sb_ok) begin
      led_d = SSS_LED_GREEN;
    end else begin
      led_d = SSS_LED_AMBER;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      LED_GREEN <= 1'b0;
      LED_AMBER <= 1'b0;
    end else begin
      LED_GREEN <= (led_d == SSS_LED_GREEN);
      LED_AMBER <= (led_d == SSS_LED_AMBER);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_pg_needs_rails: assert property (@(posedge CLOCK) disable iff (RESET) // [RULE_01]
    POWER_GOOD |-> (MAIN_IN_REG || !DC_INPUT_OK) && STANDBY_IN_REG)
    else $error("power-good high without rails");
  a_fault_stops_main: assert property (@(posedge CLOCK) disable iff (RESET) // [RULE_04]
    fault |=> !MAIN_OUTPUT_RAIL_EN)
    else $error("main rail on during board fault");
  a_alert_forces_fan: assert property (@(posedge CLOCK) disable iff (RESET) // [RULE_02]
    (!alert_sync_q[1] && MAIN_OUTPUT_RAIL_EN) |=> FAN_FORCE_MAX)
    else $error("alert did not force fan");
  a_standby_ignores: assert property (@(posedge CLOCK) disable iff (RESET) // [RULE_03]
    (!MAIN_OUTPUT_RAIL_EN && !FAN_AUTO_MAX) |=> !FAN_FORCE_MAX)
    else $error("fan forced in standby");
  a_disable_main: assert property (@(posedge CLOCK) disable iff (RESET) // [RULE_11]
    $rose(en_n) |-> ##[1:2] !MAIN_OUTPUT_RAIL_EN)
    else $error("main not disabled after enable release");
  a_disable_pg: assert property (@(posedge CLOCK) disable iff (RESET) // [RULE_12]
    $rose(en_n) |-> ##[1:2] !POWER_GOOD)
    else $error("power-good not dropped after disable");
  a_pg_rise_rails: assert property (@(posedge CLOCK) disable iff (RESET) // [RULE_05]
    $rose(POWER_GOOD) |-> $past(pg_cnt_q) == MS_ZERO && $past(both_ok))
    else $error("power-good rose early");
  a_pg_low_time: assert property (@(posedge CLOCK) disable iff (RESET) // [RULE_09]
    $rose(POWER_GOOD) |-> $past(pg_low_q) == MS_ZERO)
    else $error("power-good low time too short");
endmodule : sss_top

// file: logic/sss_pkg.sv
// Purpose: Constants for the supply status sequencer.
// Assumes: 10 MHz controller clock, one millisecond tick.
// Notes:   Times are kept in their own unit and converted to cycles or ticks here.
package sss_pkg;
  localparam int unsigned CLK_HZ           = 10_000_000;
  localparam int unsigned TICK_MS          = 1;
  localparam int unsigned TICK_CYCLES      = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned PG_DEL_MIN_MS    = 5;
  localparam int unsigned PG_DEL_MAX_MS    = 400;
  localparam int unsigned PG_DEL_MS        = 10;
  localparam int unsigned SB_TO_MAIN_MIN_MS = 50;
  localparam int unsigned SB_TO_MAIN_MAX_MS = 1000;
  localparam int unsigned SB_TO_MAIN_MS    = 100;
  localparam int unsigned EN_TO_MAIN_MS    = 10;
  localparam int unsigned PG_WARN_MS       = 1;
  localparam int unsigned PG_HOLDUP_MS     = 4;
  localparam int unsigned PG_LOW_MS        = 100;
  localparam int unsigned RAIL_OFF_MS      = 1000;
  localparam int unsigned BLINK_1HZ_MS     = 500;
  localparam int unsigned BLINK_2HZ_MS     = 250;
  localparam int unsigned MS_W             = 11;
  localparam int unsigned TICK_W           = 14;
  localparam logic [MS_W-1:0]   MS_ZERO    = 11'h000;
  localparam logic [MS_W-1:0]   MS_ONE     = 11'h001;
  localparam logic [TICK_W-1:0] TICK_ZERO  = 14'h0000;
  localparam logic [TICK_W-1:0] TICK_ONE   = 14'h0001;
  localparam logic [TICK_W-1:0] TICK_LAST  = TICK_W'(TICK_CYCLES - 1);

  typedef enum logic [4:0] {
    SSS_OFF    = 5'h01,
    SSS_WAIT   = 5'h02,
    SSS_RISE   = 5'h04,
    SSS_ON     = 5'h08,
    SSS_HOLD   = 5'h10
  } sss_state_t;

  typedef enum logic [1:0] {
    SSS_LED_OFF   = 2'h0,
    SSS_LED_GREEN = 2'h1,
    SSS_LED_AMBER = 2'h2
  } sss_led_t;
endpackage : sss_pkg

// file: dv/sss_rail_model.sv
// Purpose: Rail-side model that answers the sequencer's rail enables.
// Assumes: Rails settle a fixed number of cycles after their enables change.
// Notes:   Delays are parameters, so a prompt or a slow rail can be chosen.
`timescale 1ns/100ps
module sss_rail_model #(
  parameter int RISE_CYC = 100,
  parameter int FALL_CYC = 10500,
  parameter int SB_FALL_CYC = 100000
) (
  input  wire logic CLOCK,
  input  wire logic DC_INPUT_OK,
  input  wire logic STANDBY_ENABLE,
  input  wire logic MAIN_OUTPUT_RAIL_EN,
  output logic      STANDBY_IN_REG,
  output logic      MAIN_IN_REG
);
  int cnt_q = 0;
  int sb_cnt_q = 0;

  initial begin
    STANDBY_IN_REG = 1'h0;
    MAIN_IN_REG    = 1'h0;
  end

  // ----------------------------------------------------------------
  // Rail settling
  // ----------------------------------------------------------------
  // The main rail holds up after its enable falls, like real output capacitance.
  always @(posedge CLOCK) begin
    // The standby rail also holds up for a while after its supply goes away.
    sb_cnt_q <= ((DC_INPUT_OK & STANDBY_ENABLE) != STANDBY_IN_REG) ? sb_cnt_q + 1 : 0;
    if (DC_INPUT_OK && STANDBY_ENABLE) begin
      STANDBY_IN_REG <= 1'h1;
    end else if (sb_cnt_q >= SB_FALL_CYC) begin
      STANDBY_IN_REG <= 1'h0;
    end
    cnt_q          <= (MAIN_OUTPUT_RAIL_EN != MAIN_IN_REG) ? cnt_q + 1 : 0;
    if (MAIN_OUTPUT_RAIL_EN && cnt_q >= RISE_CYC) begin
      MAIN_IN_REG <= 1'h1;
    end
    if (!MAIN_OUTPUT_RAIL_EN && cnt_q >= FALL_CYC) begin
      MAIN_IN_REG <= 1'h0;
    end
  end
endmodule : sss_rail_model

// file: dv/testbench.sv
// Purpose: Self-checking bench for the supply status sequencer.
// Assumes: A shortened millisecond tick of T clock cycles keeps the run short.
// Notes:   Driver queues expected outputs; a monitor compares them.
`timescale 1ns/100ps
module testbench;
  import sss_pkg::*;
  typedef struct {string name; logic [6:0] exp; logic [6:0] msk;} sss_note_t;
  localparam int T = 10;
  localparam int B_MIR = 6;
  localparam int B_PG = 5;
  localparam int B_MAIN = 3;
  logic CLOCK = 1'h0, RESET = 1'h1, MAIN_ENABLE_N = 1'h1, BOARD_ALERT_N = 1'h1;
  logic BOARD_FAULT_IN = 1'h0, DC_INPUT_OK = 1'h0, FAN_ERROR_MAJOR = 1'h0, WARN_ACTIVE = 1'h0;
  logic PARALLEL_STANDBY = 1'h0, FAULT_SHUTDOWN = 1'h0, BOOTLOADING = 1'h0, FAN_AUTO_MAX = 1'h0;
  logic STANDBY_IN_REG, MAIN_IN_REG, POWER_GOOD, STANDBY_ENABLE;
  logic MAIN_OUTPUT_RAIL_EN, FAN_FORCE_MAX, LED_GREEN, LED_AMBER;
  int failures = 0, n_compared = 0, seed = 32'h78bd7f64, n;
  sss_note_t notes[$];
  sss_note_t cur;
  wire logic [6:0] obs = {MAIN_IN_REG, POWER_GOOD, STANDBY_ENABLE, MAIN_OUTPUT_RAIL_EN,
                          FAN_FORCE_MAX, LED_GREEN, LED_AMBER};

  always #50 CLOCK = ~CLOCK;

  sss_top #(.TICK_CYC(T)) dut (.CLOCK(CLOCK), .RESET(RESET), .MAIN_ENABLE_N(MAIN_ENABLE_N),
    .BOARD_ALERT_N(BOARD_ALERT_N), .BOARD_FAULT_IN(BOARD_FAULT_IN), .DC_INPUT_OK(DC_INPUT_OK),
    .STANDBY_IN_REG(STANDBY_IN_REG), .MAIN_IN_REG(MAIN_IN_REG), .PARALLEL_STANDBY(PARALLEL_STANDBY),
    .FAULT_SHUTDOWN(FAULT_SHUTDOWN), .FAN_ERROR_MAJOR(FAN_ERROR_MAJOR), .WARN_ACTIVE(WARN_ACTIVE),
    .BOOTLOADING(BOOTLOADING), .FAN_AUTO_MAX(FAN_AUTO_MAX), .POWER_GOOD(POWER_GOOD),
    .STANDBY_ENABLE(STANDBY_ENABLE), .MAIN_OUTPUT_RAIL_EN(MAIN_OUTPUT_RAIL_EN),
    .FAN_FORCE_MAX(FAN_FORCE_MAX), .LED_GREEN(LED_GREEN), .LED_AMBER(LED_AMBER));

  sss_rail_model #(.RISE_CYC(T), .FALL_CYC(T + T / 2), .SB_FALL_CYC(10 * T)) rails (.CLOCK(CLOCK),
    .DC_INPUT_OK(DC_INPUT_OK), .STANDBY_ENABLE(STANDBY_ENABLE),
    .MAIN_OUTPUT_RAIL_EN(MAIN_OUTPUT_RAIL_EN), .STANDBY_IN_REG(STANDBY_IN_REG),
    .MAIN_IN_REG(MAIN_IN_REG));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  task automatic cyc(input int k);
    repeat (k) @(posedge CLOCK);
  endtask : cyc

  // Notes are queued off the edge, so the monitor sees settled outputs.
  task automatic note(input string nm, input logic [6:0] e, input logic [6:0] m);
    @(negedge CLOCK);
    notes.push_back('{nm, e, m});
  endtask : note

  task automatic wait_bit(input int idx, input logic v, input int lim, output int c);
    c = 0;
    while (obs[idx] !== v && c < lim) begin
      @(posedge CLOCK);
      c++;
    end
    if (obs[idx] !== v) begin
      failures++;
      $display("unexpected timeout: output bit %0d expected %b seen %b", idx, v, obs[idx]);
      end_of_test();
    end
  endtask : wait_bit

  task automatic range(input string nm, input int c, input int lo, input int hi);
    n_compared++;
    if (c < lo || c > hi) begin
      failures++;
      $display("unexpected %s: expected %0d..%0d seen %0d", nm, lo, hi, c);
    end
  endtask : range

  // ----------------------------------------------------------------
  // Monitor
  // ----------------------------------------------------------------
  always @(posedge CLOCK) begin
    if (notes.size() > 0) begin
      cur = notes.pop_front();
      n_compared++;
      if ((obs & cur.msk) !== (cur.exp & cur.msk)) begin
        failures++;
        $display("unexpected %s: expected %b seen %b", cur.name, cur.exp & cur.msk, obs & cur.msk);
      end
    end
  end

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial begin
    cyc(5);
    RESET <= 1'h0;
    cyc(2);
    note("reset outputs", 7'h10, 7'h7f);
    $display("test reset done");
    cyc(1);
    DC_INPUT_OK <= 1'h1;
    cyc(5);
    for (int i = 0; i < 16; i++) begin
      BOARD_ALERT_N <= 1'($random(seed));
      cyc(4);
      note("standby fan", 7'h10, 7'h7d);
      cyc(1);
    end
    FAN_AUTO_MAX <= 1'h1;
    cyc(1);
    note("standby auto fan", 7'h04, 7'h04);
    cyc(1);
    FAN_AUTO_MAX <= 1'h0;
    $display("test standby alert done");
    BOARD_ALERT_N <= 1'h1;
    MAIN_ENABLE_N <= 1'h0;
    wait_bit(B_MIR, 1'h1, 400 * T, n);
    range("enable to main", n, 5 * T, 400 * T);
    wait_bit(B_PG, 1'h1, 400 * T, n);
    range("regulated to power good", n, 5 * T, 400 * T);
    cyc(2);
    note("solid green", 7'h7a, 7'h7f);
    cyc(1);
    BOARD_ALERT_N <= 1'h0;
    cyc(4);
    note("alert fan", 7'h04, 7'h04);
    cyc(1);
    BOARD_ALERT_N   <= 1'h1;
    FAN_ERROR_MAJOR <= 1'h1;
    cyc(4);
    note("fan error led", 7'h01, 7'h03);
    cyc(1);
    FAN_ERROR_MAJOR <= 1'h0;
    WARN_ACTIVE     <= 1'h1;
    cyc(4);
    note("warning led", 7'h00, 7'h02);
    cyc(1);
    WARN_ACTIVE <= 1'h0;
    $display("test power up done");
    MAIN_ENABLE_N <= 1'h1;
    wait_bit(B_MAIN, 1'h0, T, n);
    wait_bit(B_PG, 1'h0, 4 * T, n);
    wait_bit(B_MIR, 1'h0, 2 * T, n);
    range("power good warning", n, T, 2 * T);
    cyc(1);
    MAIN_ENABLE_N <= 1'h0;
    wait_bit(B_MIR, 1'h1, 400 * T, n);
    range("enable to main again", n, 5 * T, 400 * T);
    cyc(11 * T);
    note("power good held low", 7'h40, 7'h60);
    $display("test disable done");
    cyc(1);
    BOARD_FAULT_IN <= 1'h1;
    wait_bit(B_MAIN, 1'h0, T, n);
    note("fault shutdown", 7'h00, 7'h28);
    cyc(1);
    BOARD_FAULT_IN <= 1'h0;
    wait_bit(B_MAIN, 1'h1, 200 * T, n);
    FAULT_SHUTDOWN <= 1'h1;
    cyc(1);
    FAULT_SHUTDOWN <= 1'h0;
    cyc(200 * T);
    note("latched shutdown", 7'h01, 7'h09);
    cyc(1);
    MAIN_ENABLE_N <= 1'h1;
    cyc(5);
    MAIN_ENABLE_N <= 1'h0;
    wait_bit(B_MIR, 1'h1, 400 * T, n);
    range("enable clears latch", n, 5 * T, 400 * T);
    wait_bit(B_PG, 1'h1, 400 * T, n);
    $display("test fault done");
    BOOTLOADING <= 1'h1;
    n = 0;
    repeat (300 * T) begin
      @(posedge CLOCK);
      if (LED_GREEN !== 1'h1) n++;
    end
    range("bootload green off cycles", n, 1, 300 * T - 1);
    BOOTLOADING <= 1'h0;
    $display("test bootload done");
    DC_INPUT_OK <= 1'h0;
    wait_bit(B_PG, 1'h0, 10 * T, n);
    range("input loss hold-up", n, 4 * T, 6 * T);
    wait_bit(B_MIR, 1'h0, 2 * T, n);
    range("input loss warning", n, T, 2 * T);
    wait_bit(4, 1'h0, 20 * T, n);
    cyc(900 * T);
    note("rail kept off", 7'h00, 7'h13);
    cyc(1);
    PARALLEL_STANDBY <= 1'h1;
    cyc(2);
    note("parallel standby led", 7'h01, 7'h03);
    wait_bit(4, 1'h1, 200 * T, n);
    range("standby off time", n, 50 * T, 150 * T);
    $display("test input loss done");
    end_of_test();
  end
endmodule : testbench
